// file: tvcd_params.svh
/*
  Constants of the torque and velocity command decoder: timing, widths,
  scaling and reset values. Assumes a 50 MHz core clock.
*/
`ifndef TVCD_PARAMS_SVH
`define TVCD_PARAMS_SVH

// ==========================================================================
// Clock
`define TVCD_CLK_HZ        50000000
`define TVCD_CLK_NS        20

// ==========================================================================
// Timing
`define TVCD_LOSS_MS       50
`define TVCD_LOSS_CYC      ((`TVCD_CLK_HZ / 1000) * `TVCD_LOSS_MS)
`define TVCD_DISABLE_MS    10
`define TVCD_DISABLE_CYC   ((`TVCD_CLK_HZ / 1000) * `TVCD_DISABLE_MS)
`define TVCD_MIN_PHASE_NS  300
// Filter a quarter of the shortest legal phase
`define TVCD_FILT_CYC      (`TVCD_MIN_PHASE_NS / `TVCD_CLK_NS / 4)
`define TVCD_FILT_W        3
`define TVCD_PWM_MIN_HZ    20
`define TVCD_PWM_MAX_HZ    30000
`define TVCD_FREQ_MAX_HZ   500000
`define TVCD_FREQ_FULL_CYC (`TVCD_CLK_HZ / `TVCD_FREQ_MAX_HZ)

// ==========================================================================
// Widths and scaling
`define TVCD_N_IN          3
`define TVCD_CNT_W         22
`define TVCD_CNT_MAX       22'h3fffff
`define TVCD_TQ_FULL       10'h3ff
`define TVCD_TQ_FULL_INT   1023
`define TVCD_DUTY_HALF     11'h200
`define TVCD_DIV_TOP       4'ha
`define TVCD_MODE_RST      4'h1

`endif

// file: tvcd_pkg.sv
/*
  Types of the torque and velocity command decoder.
  Assumes tvcd_params.svh is on the include path.
*/
`include "tvcd_params.svh"

package tvcd_pkg;

  // ========================================================================
  // Modes and states
  typedef enum logic [3:0] {
    MODE_BIP  = 4'b0001,
    MODE_UNI  = 4'b0010,
    MODE_FREQ = 4'b0100,
    MODE_VEL  = 4'b1000
  } mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DIV1 = 3'b010,
    ST_DIV2 = 3'b100
  } div_st_t;

  // ========================================================================
  // Command carrier
  typedef logic signed [15:0] vel_t;

  typedef struct packed {
    logic       energize;
    logic       ccw;
    logic [9:0] torque;
    vel_t       velocity;
  } cmd_t;

endpackage : tvcd_pkg

// file: cmd_input_filter.sv
/*
  Two-stage synchroniser and glitch filter for the enable and two command
  inputs. Assumes inputs are held at least the filter length per phase.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tvcd_params.svh"

module cmd_input_filter (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst_n,
  input  wire logic [`TVCD_N_IN-1:0]  i_raw,
  output logic      [`TVCD_N_IN-1:0]  o_level,
  output logic      [`TVCD_N_IN-1:0]  o_rise,
  output logic      [`TVCD_N_IN-1:0]  o_fall
);

  // ========================================================================
  // Per-input filter
  for (genvar g = 0; g < `TVCD_N_IN; g++) begin : g_ch
    logic                    s1_r, s1_nxt;
    logic                    s2_r, s2_nxt;
    logic                    lvl_r, lvl_nxt;
    logic                    rise_r, rise_nxt;
    logic                    fall_r, fall_nxt;
    logic [`TVCD_FILT_W-1:0] cnt_r, cnt_nxt;

    always_comb begin
      s1_nxt  = i_raw[g];
      s2_nxt  = s1_r;
      lvl_nxt = lvl_r;
      cnt_nxt = '0;
      // Level flips only after FILT_CYC disagreeing samples
      if (s2_r != lvl_r) begin
        if (cnt_r == `TVCD_FILT_W'(`TVCD_FILT_CYC - 1)) begin
          lvl_nxt = s2_r;
        end else begin
          cnt_nxt = cnt_r + `TVCD_FILT_W'(1);
        end
      end
      rise_nxt = lvl_nxt & ~lvl_r;
      fall_nxt = ~lvl_nxt & lvl_r;
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        s1_r   <= 1'b0;
        s2_r   <= 1'b0;
        lvl_r  <= 1'b0;
        rise_r <= 1'b0;
        fall_r <= 1'b0;
        cnt_r  <= '0;
      end else begin
        s1_r   <= s1_nxt;
        s2_r   <= s2_nxt;
        lvl_r  <= lvl_nxt;
        rise_r <= rise_nxt;
        fall_r <= fall_nxt;
        cnt_r  <= cnt_nxt;
      end
    end

    assign o_level[g] = lvl_r;
    assign o_rise[g]  = rise_r;
    assign o_fall[g]  = fall_r;
  end

endmodule : cmd_input_filter

`default_nettype wire

// file: torque_velocity_command_decoder.sv
/*
  Servo command decoder: bipolar PWM, unipolar PWM and frequency torque
  modes, and four-velocity select with ramping. Assumes the command inputs
  are synchronous-sampled here and the mode is changed only while disabled.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tvcd_params.svh"

module torque_velocity_command_decoder
  import tvcd_pkg::*;
#(
  parameter int unsigned LOSS_CYC    = `TVCD_LOSS_CYC,
  parameter int unsigned DISABLE_CYC = `TVCD_DISABLE_CYC
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_enable,
  input  wire logic        i_in_a,
  input  wire logic        i_in_b,
  input  wire mode_t       i_mode,
  input  wire logic [8:0]  i_deadband,
  input  wire vel_t        i_velocity [4],
  input  wire logic [15:0] i_accel,
  output mode_t            o_mode,
  output logic             o_signal_ok,
  output logic [10:0]      o_duty,
  output cmd_t             o_cmd
);

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ========================================================================
  // Input conditioning
  logic [2:0] lvl, rise, fall;
  logic       en_f, a_f, b_f;

  cmd_input_filter u_filter (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_raw      ({i_in_b, i_in_a, i_enable}),
    .o_level    (lvl),
    .o_rise     (rise),
    .o_fall     (fall)
  );

  assign en_f = lvl[0];
  assign a_f  = lvl[1];
  assign b_f  = lvl[2];

  // ========================================================================
  // Mode hold
  mode_t mode_r, mode_nxt;

  // Mode only follows the input while disabled, so no path switches mid-run
  always_comb begin
    mode_nxt = en_f ? mode_r : i_mode;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mode_r <= mode_t'(`TVCD_MODE_RST);
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ========================================================================
  // Period, high time and loss measurement
  logic [`TVCD_CNT_W-1:0] per_cnt_r, per_cnt_nxt, hi_cnt_r, hi_cnt_nxt;
  logic [`TVCD_CNT_W-1:0] per_lat_r, per_lat_nxt, hi_lat_r, hi_lat_nxt;
  logic [`TVCD_CNT_W-1:0] loss_cnt_r, loss_cnt_nxt;
  logic                   seen_r, seen_nxt, start_r, start_nxt;
  logic                   loss;

  // 22-bit counters cover the 50 ms period of the slowest input
  assign loss = (loss_cnt_r >= `TVCD_CNT_W'(LOSS_CYC));

  always_comb begin
    per_cnt_nxt = per_cnt_r;
    hi_cnt_nxt  = hi_cnt_r;
    if (per_cnt_r != `TVCD_CNT_MAX) begin
      per_cnt_nxt = per_cnt_r + `TVCD_CNT_W'(1);
    end
    if (b_f && hi_cnt_r != `TVCD_CNT_MAX) begin
      hi_cnt_nxt = hi_cnt_r + `TVCD_CNT_W'(1);
    end
    if (rise[2]) begin
      per_cnt_nxt = `TVCD_CNT_W'(1);
      hi_cnt_nxt  = `TVCD_CNT_W'(1);
    end
    hi_lat_nxt   = fall[2] ? hi_cnt_r : hi_lat_r;
    per_lat_nxt  = rise[2] ? per_cnt_r : per_lat_r;
    start_nxt    = rise[2] && seen_r;
    seen_nxt     = rise[2] | (seen_r & ~loss);
    loss_cnt_nxt = loss ? loss_cnt_r : loss_cnt_r + `TVCD_CNT_W'(1);
    if (rise[2] || fall[2]) begin
      loss_cnt_nxt = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      per_cnt_r  <= '0;
      hi_cnt_r   <= '0;
      per_lat_r  <= '0;
      hi_lat_r   <= '0;
      loss_cnt_r <= '0;
      seen_r     <= 1'b0;
      start_r    <= 1'b0;
    end else begin
      per_cnt_r  <= per_cnt_nxt;
      hi_cnt_r   <= hi_cnt_nxt;
      per_lat_r  <= per_lat_nxt;
      hi_lat_r   <= hi_lat_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      seen_r     <= seen_nxt;
      start_r    <= start_nxt;
    end
  end

  // ========================================================================
  // Sequential divider: duty or rate, then deadband scaling
  div_st_t     st_r, st_nxt;
  logic [33:0] rem_r, rem_nxt, shifted;
  logic [21:0] dsr_r, dsr_nxt;
  logic [10:0] q_r, q_nxt, q_fin, duty_r, duty_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [9:0]  mag_r, mag_nxt, abs_w, mag_fin;
  logic        ccw_r, ccw_nxt, valid_r, valid_nxt, ccw_w;

  always_comb begin
    st_nxt    = st_r;
    rem_nxt   = rem_r;
    dsr_nxt   = dsr_r;
    q_nxt     = q_r;
    bit_nxt   = bit_r;
    duty_nxt  = duty_r;
    mag_nxt   = mag_r;
    ccw_nxt   = ccw_r;
    valid_nxt = valid_r;
    shifted   = {12'h0, dsr_r} << bit_r;
    q_fin     = q_r;
    if (rem_r >= shifted) begin
      q_fin[bit_r] = 1'b1;
    end
    mag_fin = (q_fin > 11'(`TVCD_TQ_FULL)) ? `TVCD_TQ_FULL : q_fin[9:0];
    ccw_w   = (q_fin >= `TVCD_DUTY_HALF);
    abs_w   = ccw_w ? 10'(q_fin - `TVCD_DUTY_HALF)
                    : 10'(`TVCD_DUTY_HALF - q_fin);
    case (st_r)
      ST_IDLE: begin
        if (start_r) begin
          bit_nxt = `TVCD_DIV_TOP;
          q_nxt   = '0;
          dsr_nxt = per_lat_r;
          st_nxt  = ST_DIV1;
          if (mode_r == MODE_FREQ) begin
            rem_nxt = 34'(`TVCD_FREQ_FULL_CYC * `TVCD_TQ_FULL_INT);
            // Faster than full scale would overflow the quotient
            if (per_lat_r < 22'(`TVCD_FREQ_FULL_CYC)) begin
              mag_nxt   = `TVCD_TQ_FULL;
              valid_nxt = 1'b1;
              st_nxt    = ST_IDLE;
            end
          end else begin
            rem_nxt = {2'h0, hi_lat_r, 10'h0};
          end
        end
      end
      ST_DIV1, ST_DIV2: begin
        if (rem_r >= shifted) begin
          rem_nxt = rem_r - shifted;
        end
        q_nxt   = q_fin;
        bit_nxt = bit_r - 4'h1;
        if (bit_r == 4'h0) begin
          bit_nxt   = 4'h0;
          st_nxt    = ST_IDLE;
          valid_nxt = 1'b1;
          mag_nxt   = mag_fin;
          if (st_r == ST_DIV1 && mode_r != MODE_FREQ) begin
            duty_nxt = q_fin;
          end
          if (st_r == ST_DIV1 && mode_r == MODE_BIP) begin
            ccw_nxt = ccw_w;
            mag_nxt = '0;
            if (abs_w > 10'(i_deadband)) begin
              // Steeper gain keeps full torque at the duty extremes
              rem_nxt = 34'(abs_w - 10'(i_deadband)) * 34'(1023);
              dsr_nxt = 22'(10'(`TVCD_DUTY_HALF) - 10'(i_deadband));
              bit_nxt = `TVCD_DIV_TOP;
              q_nxt   = '0;
              st_nxt  = ST_DIV2;
              valid_nxt = valid_r;
              // Old torque stands until the scaled value is ready
              mag_nxt   = mag_r;
              ccw_nxt   = ccw_r;
            end
          end
          if (st_r == ST_DIV2) begin
            ccw_nxt = (duty_r >= `TVCD_DUTY_HALF);
          end
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
    if (loss) begin
      valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st_r    <= ST_IDLE;
      rem_r   <= '0;
      dsr_r   <= '0;
      q_r     <= '0;
      bit_r   <= '0;
      duty_r  <= '0;
      mag_r   <= '0;
      ccw_r   <= 1'b0;
      valid_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      rem_r   <= rem_nxt;
      dsr_r   <= dsr_nxt;
      q_r     <= q_nxt;
      bit_r   <= bit_nxt;
      duty_r  <= duty_nxt;
      mag_r   <= mag_nxt;
      ccw_r   <= ccw_nxt;
      valid_r <= valid_nxt;
    end
  end

  // ========================================================================
  // Velocity select and ramp
  vel_t               vel_r, vel_nxt, vel_q_r, target;
  logic signed [16:0] diff, acc, dlt;

  assign target = i_velocity[{b_f, a_f}];
  assign acc    = $signed({1'b0, i_accel});
  assign diff   = 17'(target) - 17'(vel_r);
  assign dlt    = 17'(vel_r) - 17'(vel_q_r);

  // Target follows the inputs every cycle, so ramping starts at once
  always_comb begin
    vel_nxt = target;
    if (!(en_f && mode_r == MODE_VEL)) begin
      vel_nxt = '0;
    end else if (diff > acc) begin
      vel_nxt = 16'(17'(vel_r) + acc);
    end else if (diff < -acc) begin
      vel_nxt = 16'(17'(vel_r) - acc);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      vel_r   <= '0;
      vel_q_r <= '0;
    end else begin
      vel_r   <= vel_nxt;
      vel_q_r <= vel_r;
    end
  end

  // ========================================================================
  // Command output
  cmd_t cmd_r, cmd_nxt;

  always_comb begin
    cmd_nxt          = '0;
    cmd_nxt.energize = en_f;
    if (en_f) begin
      case (mode_r)
        MODE_BIP: begin
          if (!a_f && valid_r) begin
            cmd_nxt.torque = mag_r;
            cmd_nxt.ccw    = ccw_r;
          end
        end
        MODE_UNI, MODE_FREQ: begin
          if (valid_r) begin
            cmd_nxt.torque = mag_r;
            cmd_nxt.ccw    = !a_f;
          end
        end
        MODE_VEL: cmd_nxt.velocity = vel_r;
        default:  cmd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  assign o_cmd       = cmd_r;
  assign o_mode      = mode_r;
  assign o_signal_ok = valid_r;
  assign o_duty      = duty_r;

  // ========================================================================
  // Checks
  logic [`TVCD_CNT_W-1:0] dis_cnt_r;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n || i_enable || !o_cmd.energize) begin
      dis_cnt_r <= '0;
    end else begin
      dis_cnt_r <= dis_cnt_r + `TVCD_CNT_W'(1);
    end
  end

  AST_INHIBIT: assert property (
    (en_f && mode_r == MODE_BIP && a_f) |=> (o_cmd.torque == 10'h0))
    else $error("torque not zero under inhibit");

  AST_DISABLE_FAST: assert property (
    (!i_enable) [*8] |-> (!o_cmd.energize && o_cmd.torque == 10'h0))
    else $error("motor still driven after enable dropped");

  AST_DISABLE_TIME: assert property (
    dis_cnt_r < `TVCD_CNT_W'(DISABLE_CYC))
    else $error("disable response too slow");

  AST_OFF: assert property (
    !en_f |=> (!o_cmd.energize && o_cmd.velocity == 16'sh0))
    else $error("disabled motor still commanded");

  AST_LOSS: assert property (
    loss |-> ##2 (o_cmd.torque == 10'h0))
    else $error("torque kept after input loss");

  AST_UNI_DIR: assert property (
    (en_f && mode_r == MODE_UNI && valid_r) |=> (o_cmd.ccw == !$past(a_f)))
    else $error("unipolar direction wrong");

  AST_VEL_NO_TORQUE: assert property (
    (mode_r == MODE_VEL) |=> (o_cmd.torque == 10'h0))
    else $error("torque driven in velocity mode");

  AST_DEADBAND: assert property (
    (st_r == ST_DIV1 && bit_r == 4'h0 && mode_r == MODE_BIP
     && abs_w <= 10'(i_deadband)) |=> (mag_r == 10'h0 && st_r == ST_IDLE))
    else $error("deadband not applied");

  AST_DIV_DONE: assert property (
    (st_r == ST_DIV1) |-> ##[1:24] (st_r == ST_IDLE))
    else $error("divider did not finish");

  AST_FREQ_FULL: assert property (
    (st_r == ST_IDLE && start_r && mode_r == MODE_FREQ
     && per_lat_r < 22'(`TVCD_FREQ_FULL_CYC)) |=> (mag_r == `TVCD_TQ_FULL))
    else $error("frequency full scale missed");

  AST_RAMP: assert property (
    (en_f && mode_r == MODE_VEL && $past(en_f && mode_r == MODE_VEL))
    |-> (dlt <= acc && dlt >= -acc))
    else $error("velocity step exceeds ramp");

endmodule : torque_velocity_command_decoder

`default_nettype wire

// file: pwm_source.sv
/*
  Controller model: drives the second command input with a free-running
  PWM or pulse train, or holds it at a static level.
  The bench changes high time and period between cases, also while running.
*/
`timescale 1ns/10ps
`default_nettype none

module pwm_source (
  input  wire logic        i_core_clk,
  input  wire logic        i_run,
  input  wire logic        i_static,
  input  wire logic [15:0] i_high,
  input  wire logic [15:0] i_period,
  output logic             o_pulse
);
  logic [15:0] cnt_r;

  // ==========================================================================
  // Pulse generation
  always_ff @(posedge i_core_clk) begin
    if (!i_run || cnt_r >= i_period - 16'h0001) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'h0001;
    end
    // Bench keeps phases of 15 cycles or more and periods within range
    o_pulse <= i_run ? (cnt_r < i_high) : i_static;
  end
endmodule : pwm_source

`default_nettype wire

// file: torque_velocity_command_decoder_tb.sv
/*
  Self-checking bench for the command decoder: mode sequences with
  expected torque, direction, loss and velocity values.
  Assumes the controller model pwm_source drives the second input.
*/
`timescale 1ns/10ps
`default_nettype none

module torque_velocity_command_decoder_tb;
  import tvcd_pkg::*;
  // Loss time kept short but above the 2048-cycle PWM period
  localparam int LOSS = 2500;
  localparam int CEIL = 100000;

  logic        clk, rst_n, enable, in_a, in_b, run, stat;
  mode_t       mode, o_mode;
  logic [8:0]  db;
  vel_t        vel [4];
  vel_t        prev;
  logic [15:0] accel, high, period;
  logic        signal_ok;
  logic [10:0] duty;
  cmd_t        cmd;
  int          bad_count, checks, cycles;

  torque_velocity_command_decoder #(
    .LOSS_CYC    (LOSS),
    .DISABLE_CYC (500)
  ) dut (
    .i_core_clk  (clk),
    .i_rst_n     (rst_n),
    .i_enable    (enable),
    .i_in_a      (in_a),
    .i_in_b      (in_b),
    .i_mode      (mode),
    .i_deadband  (db),
    .i_velocity  (vel),
    .i_accel     (accel),
    .o_mode      (o_mode),
    .o_signal_ok (signal_ok),
    .o_duty      (duty),
    .o_cmd       (cmd)
  );

  pwm_source ctl (
    .i_core_clk (clk),
    .i_run      (run),
    .i_static   (stat),
    .i_high     (high),
    .i_period   (period),
    .o_pulse    (in_b)
  );

  // ==========================================================================
  // Helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic off_check();
    @(posedge clk);
    enable <= 1'b0;
    tick(12);
    check(cmd.energize === 1'b0 && cmd.torque === 10'h000,
          "disable");
  endtask : off_check

  task automatic run_case(input mode_t m, input logic [8:0] d,
                          input logic [15:0] h, input logic [15:0] p,
                          input logic a, input logic xccw, input int xtq);
    int diff;
    off_check();
    mode   <= m;
    db     <= d;
    in_a   <= a;
    high   <= h;
    period <= p;
    run    <= 1'b1;
    tick(10);
    enable <= 1'b1;
    tick(3 * int'(p) + 60);
    diff = int'(cmd.torque) - xtq;
    check(o_mode === m, "held mode");
    check(cmd.energize === 1'b1 && signal_ok === 1'b1, "energize");
    check(!$isunknown(cmd.torque) && diff <= 3 && diff >= -3,
          "torque");
    check(xtq == 0 || cmd.ccw === xccw, "direction");
    check(m == MODE_FREQ || duty === 11'(int'(h) * 1024 / int'(p)),
          "duty");
  endtask : run_case

  task automatic loss(input logic lvl);
    run  <= 1'b0;
    stat <= lvl;
    tick(LOSS + 40);
    check(signal_ok === 1'b0 && cmd.torque === 10'h000,
          "input lost");
  endtask : loss

  // ==========================================================================
  // Clock and timeout
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == CEIL) begin
      bad_count++;
      $display("MISMATCH at %0t: timeout", $time);
      summarize();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    rst_n  = 1'b0;
    enable = 1'b0;
    in_a   = 1'b0;
    run    = 1'b0;
    stat   = 1'b0;
    mode   = MODE_BIP;
    db     = 9'h000;
    accel  = 16'h0100;
    high   = 16'h0000;
    period = 16'h0800;
    vel[0] = 16'sh0300;
    vel[1] = 16'sh1000;
    vel[2] = -16'sh0800;
    vel[3] = 16'sh0400;
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    check(cmd.energize === 1'b0 && o_mode === MODE_BIP,
          "reset state");
    // Period 2048 cycles, so duty is half the high count
    run_case(MODE_BIP, 9'h000, 16'h0200, 16'h0800, 1'b0, 1'b0, 511);
    loss(1'b1);
    run_case(MODE_BIP, 9'h000, 16'h0600, 16'h0800, 1'b0, 1'b1, 511);
    run_case(MODE_BIP, 9'h000, 16'h0600, 16'h0800, 1'b1, 1'b1, 0);
    run_case(MODE_BIP, 9'h033, 16'h044c, 16'h0800, 1'b0, 1'b1, 0);
    run_case(MODE_BIP, 9'h033, 16'h0708, 16'h0800, 1'b0, 1'b1, 747);
    run_case(MODE_UNI, 9'h000, 16'h0400, 16'h0800, 1'b1, 1'b0, 512);
    run_case(MODE_UNI, 9'h000, 16'h0400, 16'h0800, 1'b0, 1'b1, 512);
    loss(1'b0);
    run_case(MODE_FREQ, 9'h000, 16'h0064, 16'h00c8, 1'b1, 1'b0, 511);
    run_case(MODE_FREQ, 9'h000, 16'h0064, 16'h00c8, 1'b0, 1'b1, 511);
    // Top legal rate gives full-scale torque
    run_case(MODE_FREQ, 9'h000, 16'h0032, 16'h0064, 1'b1, 1'b0, 1023);
    loss(1'b0);
    off_check();
    mode <= MODE_VEL;
    in_a <= 1'b0;
    stat <= 1'b0;
    tick(10);
    enable <= 1'b1;
    tick(200);
    check(cmd.velocity === vel[0], "first velocity");
    prev = cmd.velocity;
    for (int s = 1; s < 4; s++) begin
      in_a <= s[0];
      stat <= s[1];
      tick(14);
      check(cmd.velocity !== prev, "ramp start");
      tick(200);
      check(cmd.velocity === vel[s], "selected velocity");
      prev = cmd.velocity;
    end
    off_check();
    summarize();
  end
endmodule : torque_velocity_command_decoder_tb

`default_nettype wire
